// File: design/osw_pkg.sv
// constants, bus carrier and state type for the clock source switch
package osw_pkg;
	////////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [1:0] OSW_ADDR_OSC_CTRL = 2'h0;
	localparam logic [1:0] OSW_ADDR_TUNE     = 2'h1;
	localparam logic [1:0] OSW_ADDR_SEC_CTRL = 2'h2;
	////////////////////////////////////////////////////////////////////////////
	// oscillator_control fields
	localparam int OSW_IDLE_BIT     = 7;
	localparam int OSW_FREQ_LSB     = 4;
	localparam int OSW_STARTUP_BIT  = 3;
	localparam int OSW_FSTABLE_BIT  = 2;
	localparam int OSW_SEL_LSB      = 0;
	// oscillator_tuning fields
	localparam int OSW_LOWSRC_BIT   = 7;
	localparam int OSW_MULT_BIT     = 6;
	localparam int OSW_TUNE_LSB     = 0;
	// secondary_timer_control fields
	localparam int OSW_SEC_ACT_BIT  = 6;
	localparam int OSW_SEC_EN_BIT   = 3;
	////////////////////////////////////////////////////////////////////////////
	// reset values and encodings
	localparam logic [2:0] OSW_FREQ_RST  = 3'h4;
	localparam logic [2:0] OSW_FREQ_LOW  = 3'h0;
	localparam logic [1:0] OSW_SEL_RST   = 2'h0;
	localparam logic [1:0] OSW_SRC_PRI   = 2'h0;
	localparam logic [1:0] OSW_SRC_SEC   = 2'h1;
	localparam logic [4:0] OSW_TUNE_RST  = 5'h00;
	localparam logic [3:0] OSW_MODE_INTA = 4'h8;
	localparam logic [3:0] OSW_MODE_INTB = 4'h9;
	////////////////////////////////////////////////////////////////////////////
	// switch pause lengths, in source edges
	localparam logic [1:0] OSW_OLD_TICKS = 2'h2;
	localparam logic [1:0] OSW_NEW_TICKS = 2'h3;
	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} osw_bus_req_t;

	typedef enum logic [1:0] {
		OSW_RUN       = 2'b00,
		OSW_DRAIN_OLD = 2'b01,
		OSW_FILL_NEW  = 2'b11
	} osw_state_t;
endpackage

// File: design/osw_postscaler.sv
// internal oscillator block postscaler: fast edge divided per frequency field
`timescale 1ns/1ps
`default_nettype none
module osw_postscaler (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       fast_tick,
	input  wire logic       slow_tick,
	input  wire logic [2:0] freq_sel,
	input  wire logic       low_src,
	output logic            tick_out
);
	import osw_pkg::*;

	logic [7:0] div_reg;

	// wrap mask: 111 passes every edge, 000 divides by 256
	function automatic logic [7:0] div_mask(input logic [2:0] f);
		unique case (f)
			3'h7: div_mask = 8'h00;
			3'h6: div_mask = 8'h01;
			3'h5: div_mask = 8'h03;
			3'h4: div_mask = 8'h07;
			3'h3: div_mask = 8'h0f;
			3'h2: div_mask = 8'h1f;
			3'h1: div_mask = 8'h3f;
			3'h0: div_mask = 8'hff;
		endcase
	endfunction

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 8'h00;
		end else if (fast_tick) begin
			div_reg <= div_reg + 8'h01;
		end
	end

	// mask applies on the next edge, so a new setting acts at once
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tick_out <= 1'b0;
		end else if (freq_sel == OSW_FREQ_LOW && !low_src) begin
			tick_out <= slow_tick;
		end else begin
			tick_out <= fast_tick && ((div_reg & div_mask(freq_sel)) == div_mask(freq_sel));
		end
	end
endmodule
`default_nettype wire

// File: design/osw_clock_switch.sv
// system clock source selection, glitch-free switch and oscillator control
// Behaviour
// - select 1x takes the internal block, 01 the secondary, 00 the primary
// - every reset clears the select field, restarting on the primary oscillator
// - a write changing the select starts a switch immediately
// - clock pauses two old-source edges plus three new-source edges
// - frequency field picks 8 MHz down to 31 kHz from the internal block
// - reset sets the frequency field to the 1 MHz setting
// - a frequency write changes the internal output at once
// - at 000 low source bit picks fast/256 or the low-power oscillator
// - watchdog and monitor always run from the low-power oscillator; no monitor is built here, only the watchdog clock enable
// - startup-done reads 1 when timer expired and primary running
// - fast-stable reads 1 when fast oscillator stable and clocking; reset 0
// - secondary timer control bit 6 shows secondary clock active
// - at most one source status bit set at a time
// - idle bit picks idle or sleep on a sleep instruction; reset 0
// - selecting secondary is ignored while its enable bit is clear
// - primary mode comes from the non-volatile configuration field only
// - multiplier works only at 4 or 8 MHz settings
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module osw_clock_switch (
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	input  wire osw_pkg::osw_bus_req_t bus_req,
	output logic [7:0]                 rdata,
	input  wire logic                  pri_tick,
	input  wire logic                  sec_tick,
	input  wire logic                  fast_osc_tick,
	input  wire logic                  lp_osc_tick,
	input  wire logic                  startup_expired,
	input  wire logic                  fast_osc_stable,
	input  wire logic                  two_speed_startup_config,
	input  wire logic [3:0]            primary_mode_config,
	input  wire logic                  sleep_exec,
	output logic                       sys_clk_en,
	output logic                       wdt_clk_en,
	output logic [1:0]                 active_source,
	output logic                       switch_busy,
	output logic [4:0]                 tune_value,
	output logic                       multiplier_active,
	output logic [3:0]                 primary_mode,
	output logic                       enter_idle,
	output logic                       enter_sleep
);
	import osw_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	logic        idle_on_sleep_select_reg;
	logic [2:0]  internal_freq_select_reg;
	logic [1:0]  clock_source_select_reg;
	logic        low_freq_source_select_reg;
	logic        multiplier_enable_reg;
	logic [4:0]  tune_reg;
	logic        secondary_osc_enable_reg;
	logic [3:0]  sec_ctrl_other_reg;
	logic        cfg_loaded_reg;
	logic        two_speed_reg;
	logic [3:0]  primary_mode_reg;
	osw_state_t  state_reg;
	logic [1:0]  active_reg;
	logic [1:0]  target_reg;
	logic [1:0]  edge_cnt_reg;
	logic [7:0]  rdata_reg;
	logic        sys_clk_en_reg;
	logic        int_tick;
	logic        old_tick;
	logic        new_tick;
	logic        sel_write;
	logic [1:0]  sel_next;
	logic        primary_startup_done;
	logic        internal_fast_stable;
	logic        secondary_clock_active;
	logic        mult_allowed;

	function automatic logic pick_tick(input logic [1:0] sel, input logic p,
		input logic s, input logic i);
		if (sel[1]) begin
			pick_tick = i;
		end else if (sel[0]) begin
			pick_tick = s;
		end else begin
			pick_tick = p;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// internal block output
	osw_postscaler u_post (
		.clock     (clock),
		.rst_n     (rst_n),
		.fast_tick (fast_osc_tick),
		.slow_tick (lp_osc_tick),
		.freq_sel  (internal_freq_select_reg),
		.low_src   (low_freq_source_select_reg),
		.tick_out  (int_tick)
	);

	assign wdt_clk_en = lp_osc_tick;

	////////////////////////////////////////////////////////////////////////////
	// configuration captured after reset release, never from a run-time write
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cfg_loaded_reg   <= 1'b0;
			two_speed_reg    <= 1'b0;
			primary_mode_reg <= 4'h0;
		end else if (!cfg_loaded_reg) begin
			cfg_loaded_reg   <= 1'b1;
			two_speed_reg    <= two_speed_startup_config;
			primary_mode_reg <= primary_mode_config;
		end
	end
	assign primary_mode = primary_mode_reg;

	////////////////////////////////////////////////////////////////////////////
	// register writes
	assign sel_next  = bus_req.wdata[OSW_SEL_LSB +: 2];
	// secondary request dropped while its oscillator is off
	assign sel_write = bus_req.wr && bus_req.addr == OSW_ADDR_OSC_CTRL
		&& !(sel_next == OSW_SRC_SEC && !secondary_osc_enable_reg);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			idle_on_sleep_select_reg <= 1'b0;
			internal_freq_select_reg <= OSW_FREQ_RST;
		end else if (bus_req.wr && bus_req.addr == OSW_ADDR_OSC_CTRL) begin
			idle_on_sleep_select_reg <= bus_req.wdata[OSW_IDLE_BIT];
			internal_freq_select_reg <= bus_req.wdata[OSW_FREQ_LSB +: 3];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			clock_source_select_reg <= OSW_SEL_RST;
		end else if (sel_write) begin
			clock_source_select_reg <= sel_next;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			low_freq_source_select_reg <= 1'b0;
			multiplier_enable_reg      <= 1'b0;
			tune_reg                   <= OSW_TUNE_RST;
		end else if (bus_req.wr && bus_req.addr == OSW_ADDR_TUNE) begin
			low_freq_source_select_reg <= bus_req.wdata[OSW_LOWSRC_BIT];
			multiplier_enable_reg      <= bus_req.wdata[OSW_MULT_BIT];
			tune_reg                   <= bus_req.wdata[OSW_TUNE_LSB +: 5];
		end
	end
	assign tune_value = tune_reg;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			secondary_osc_enable_reg <= 1'b0;
			sec_ctrl_other_reg       <= 4'h0;
		end else if (bus_req.wr && bus_req.addr == OSW_ADDR_SEC_CTRL) begin
			secondary_osc_enable_reg <= bus_req.wdata[OSW_SEC_EN_BIT];
			sec_ctrl_other_reg       <= {bus_req.wdata[7], bus_req.wdata[5:4], bus_req.wdata[0]};
		end
	end

	// multiplier only in internal-block primary modes at 4 or 8 MHz
	assign mult_allowed = primary_mode_reg == OSW_MODE_INTA || primary_mode_reg == OSW_MODE_INTB;
	assign multiplier_active = multiplier_enable_reg && mult_allowed
		&& internal_freq_select_reg[2:1] == 2'b11;

	////////////////////////////////////////////////////////////////////////////
	// switch sequencer: the clock is held while old edges drain and new edges fill
	assign old_tick = pick_tick(active_reg, pri_tick, sec_tick, int_tick);
	assign new_tick = pick_tick(target_reg, pri_tick, sec_tick, int_tick);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg    <= OSW_RUN;
			target_reg   <= OSW_SEL_RST;
			edge_cnt_reg <= 2'h0;
		end else if (sel_write && sel_next != clock_source_select_reg) begin
			// a new choice restarts the handover from the current source
			state_reg    <= OSW_DRAIN_OLD;
			target_reg   <= sel_next;
			edge_cnt_reg <= 2'h0;
		end else begin
			unique case (state_reg)
				OSW_RUN: begin
					edge_cnt_reg <= 2'h0;
				end
				OSW_DRAIN_OLD: begin
					if (old_tick) begin
						if (edge_cnt_reg == OSW_OLD_TICKS - 2'h1) begin
							state_reg    <= OSW_FILL_NEW;
							edge_cnt_reg <= 2'h0;
						end else begin
							edge_cnt_reg <= edge_cnt_reg + 2'h1;
						end
					end
				end
				OSW_FILL_NEW: begin
					if (new_tick) begin
						if (edge_cnt_reg == OSW_NEW_TICKS - 2'h1) begin
							state_reg    <= OSW_RUN;
							edge_cnt_reg <= 2'h0;
						end else begin
							edge_cnt_reg <= edge_cnt_reg + 2'h1;
						end
					end
				end
				default: begin
					state_reg <= OSW_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			active_reg <= OSW_SEL_RST;
		end else if (state_reg == OSW_FILL_NEW && new_tick
			&& edge_cnt_reg == OSW_NEW_TICKS - 2'h1
			&& !(sel_write && sel_next != clock_source_select_reg)) begin
			active_reg <= target_reg;
		end
	end
	assign active_source = active_reg;
	assign switch_busy   = state_reg != OSW_RUN;

	// clock edges withheld for the whole pause, so no short pulse escapes
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sys_clk_en_reg <= 1'b0;
		end else begin
			sys_clk_en_reg <= (state_reg == OSW_RUN) && old_tick;
		end
	end
	assign sys_clk_en = sys_clk_en_reg;

	////////////////////////////////////////////////////////////////////////////
	// status, at most one set by construction of active_reg
	assign primary_startup_done = active_reg == OSW_SRC_PRI && !switch_busy
		&& (startup_expired || (cfg_loaded_reg && !two_speed_reg));
	assign internal_fast_stable = active_reg[1] && !switch_busy && fast_osc_stable
		&& !(internal_freq_select_reg == OSW_FREQ_LOW && !low_freq_source_select_reg);
	assign secondary_clock_active = active_reg == OSW_SRC_SEC && !switch_busy;

	// sleep instruction outcome
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			enter_idle  <= 1'b0;
			enter_sleep <= 1'b0;
		end else begin
			enter_idle  <= sleep_exec && idle_on_sleep_select_reg;
			enter_sleep <= sleep_exec && !idle_on_sleep_select_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read port, data valid the cycle after the strobe; unmapped reads zero
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 8'h00;
		end else if (bus_req.rd) begin
			unique case (bus_req.addr)
				OSW_ADDR_OSC_CTRL: rdata_reg <= {idle_on_sleep_select_reg,
					internal_freq_select_reg, primary_startup_done,
					internal_fast_stable, clock_source_select_reg};
				OSW_ADDR_TUNE: rdata_reg <= {low_freq_source_select_reg,
					multiplier_enable_reg && mult_allowed, 1'b0, tune_reg};
				OSW_ADDR_SEC_CTRL: rdata_reg <= {sec_ctrl_other_reg[3],
					secondary_clock_active, sec_ctrl_other_reg[2:1],
					secondary_osc_enable_reg, 2'b00, sec_ctrl_other_reg[0]};
				default: rdata_reg <= 8'h00;
			endcase
		end
	end
	assign rdata = rdata_reg;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_sel_ignored;
		bus_req.wr && bus_req.addr == OSW_ADDR_OSC_CTRL && !secondary_osc_enable_reg
			&& bus_req.wdata[1:0] == OSW_SRC_SEC |=> $stable(clock_source_select_reg);
	endproperty
	a_sel_ignored: assert property (p_sel_ignored) else $error("secondary select taken while off");

	property p_switch_start;
		sel_write && sel_next != clock_source_select_reg |=> state_reg == OSW_DRAIN_OLD;
	endproperty
	a_switch_start: assert property (p_switch_start) else $error("switch did not start");

	property p_pause_quiet;
		switch_busy |=> !sys_clk_en;
	endproperty
	a_pause_quiet: assert property (p_pause_quiet) else $error("clock edge during switch");

	property p_handover;
		$changed(active_reg) |-> $past(state_reg) == OSW_FILL_NEW && $past(new_tick);
	endproperty
	a_handover: assert property (p_handover) else $error("handover without new edge");

	property p_one_hot;
		$onehot0({primary_startup_done, internal_fast_stable, secondary_clock_active});
	endproperty
	a_one_hot: assert property (p_one_hot) else $error("two source status bits set");

	property p_idle_pick;
		sleep_exec |=> (enter_idle == $past(idle_on_sleep_select_reg)) && (enter_sleep != enter_idle);
	endproperty
	a_idle_pick: assert property (p_idle_pick) else $error("wrong low power mode");

	property p_mult_gate;
		multiplier_active |-> internal_freq_select_reg[2:1] == 2'b11 && mult_allowed;
	endproperty
	a_mult_gate: assert property (p_mult_gate) else $error("multiplier outside 4/8 MHz");

	property p_mode_fixed;
		cfg_loaded_reg |=> $stable(primary_mode);
	endproperty
	a_mode_fixed: assert property (p_mode_fixed) else $error("primary mode changed at run time");

	property p_fstable;
		internal_fast_stable |-> fast_osc_stable && active_reg[1] && !switch_busy;
	endproperty
	a_fstable: assert property (p_fstable) else $error("fast stable without fast clock");

	property p_wdt_src;
		wdt_clk_en == lp_osc_tick;
	endproperty
	a_wdt_src: assert property (p_wdt_src) else $error("watchdog clock not low-power osc");

	c_to_sec: cover property (state_reg == OSW_FILL_NEW && target_reg == OSW_SRC_SEC ##1 state_reg == OSW_RUN);
	c_to_int: cover property (state_reg == OSW_FILL_NEW && target_reg[1] ##1 state_reg == OSW_RUN);
	c_restart: cover property (switch_busy && sel_write && sel_next != clock_source_select_reg);
	c_idle: cover property (enter_idle);
endmodule
`default_nettype wire

// File: tb/osw_osc_model.sv
// oscillator tick sources standing at the far side of the clock switch
`timescale 1ns/1ps
`default_nettype none
module osw_osc_model #(
	parameter int P_PRI  = 3,
	parameter int P_SEC  = 8,
	parameter int P_FAST = 2,
	parameter int P_LP   = 64
) (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic sec_run,
	output logic      pri_tick,
	output logic      sec_tick,
	output logic      fast_tick,
	output logic      lp_tick
);
	localparam int PER [4] = '{P_PRI, P_SEC, P_FAST, P_LP};
	int         cnt [4];
	logic [3:0] t;

	////////////////////////////////////////////////////////////////////////////
	// free counters; the secondary stays silent until software enables it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int k = 0; k < 4; k++) begin
				cnt[k] <= 0;
			end
			t <= 4'h0;
		end else begin
			for (int k = 0; k < 4; k++) begin
				cnt[k] <= (cnt[k] == PER[k] - 1) ? 0 : cnt[k] + 1;
				t[k]   <= (cnt[k] == PER[k] - 1) && (k != 1 || sec_run);
			end
		end
	end

	assign pri_tick  = t[0];
	assign sec_tick  = t[1];
	assign fast_tick = t[2];
	assign lp_tick   = t[3];
endmodule
`default_nettype wire

// File: tb/osw_clock_switch_tb.sv
// self-checking bench for the clock source switch
`timescale 1ns/1ps
`default_nettype none
module osw_clock_switch_tb;
	import osw_pkg::*;
	localparam int P_PRI  = 3;
	localparam int P_SEC  = 8;
	localparam int P_FAST = 2;
	localparam int P_LP   = 64;
	typedef struct packed {
		logic [1:0] a;
		logic [7:0] w;
		logic [7:0] e;
	} osw_row_t;
	localparam osw_row_t ROWS [7] = '{'{2'h1, 8'hff, 8'hdf}, '{2'h1, 8'h1f, 8'h1f},
		'{2'h2, 8'hff, 8'hb9}, '{2'h2, 8'hb1, 8'hb1}, '{2'h3, 8'hff, 8'h00},
		'{2'h0, 8'hfc, 8'hf8}, '{2'h0, 8'h4c, 8'h48}};

	logic         clock;
	logic         rst_n;
	osw_bus_req_t bus_req;
	logic [7:0]   rdata;
	logic         pri_tick, sec_tick, fast_tick, lp_tick, sec_run;
	logic         startup_expired, fast_osc_stable, two_speed, sleep_exec;
	logic [3:0]   mode_cfg;
	logic         sys_clk_en, wdt_clk_en, switch_busy, multiplier_active;
	logic         enter_idle, enter_sleep, busy_d;
	logic [1:0]   active_source;
	logic [4:0]   tune_value;
	logic [3:0]   primary_mode;
	int           mismatches, n_tests, glitches, wdt_bad;

	osw_osc_model #(.P_PRI(P_PRI), .P_SEC(P_SEC), .P_FAST(P_FAST), .P_LP(P_LP)) osc (
		.clock(clock), .rst_n(rst_n), .sec_run(sec_run), .pri_tick(pri_tick),
		.sec_tick(sec_tick), .fast_tick(fast_tick), .lp_tick(lp_tick));

	osw_clock_switch DUT (
		.clock(clock), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
		.pri_tick(pri_tick), .sec_tick(sec_tick), .fast_osc_tick(fast_tick),
		.lp_osc_tick(lp_tick), .startup_expired(startup_expired),
		.fast_osc_stable(fast_osc_stable), .two_speed_startup_config(two_speed),
		.primary_mode_config(mode_cfg), .sleep_exec(sleep_exec),
		.sys_clk_en(sys_clk_en), .wdt_clk_en(wdt_clk_en), .active_source(active_source),
		.switch_busy(switch_busy), .tune_value(tune_value),
		.multiplier_active(multiplier_active), .primary_mode(primary_mode),
		.enter_idle(enter_idle), .enter_sleep(enter_sleep));

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////////
	// monitors: no device clock edge inside a pause, watchdog tick untouched
	always @(posedge clock) begin
		busy_d <= switch_busy;
		if (switch_busy === 1'b1 && busy_d === 1'b1 && sys_clk_en !== 1'b0) glitches++;
	end
	always @(negedge clock) begin
		if (wdt_clk_en !== lp_tick) wdt_bad++;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock);
		bus_req.addr  <= a;
		bus_req.wdata <= d;
		bus_req.wr    <= 1'b1;
		@(posedge clock);
		bus_req.wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge clock);
		bus_req.addr <= a;
		bus_req.rd   <= 1'b1;
		@(posedge clock);
		bus_req.rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic wait_sw(output int d);
		d = 0;
		while (switch_busy === 1'b1 && d < 2000) begin
			@(posedge clock);
			#1;
			d++;
		end
	endtask

	// third interval is a full period whatever phase the write landed in
	task automatic per(output int n);
		for (int k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(posedge clock);
				#1;
				n++;
			end while (sys_clk_en !== 1'b1 && n < 4000);
		end
	endtask

	task automatic slp(input logic idle);
		@(posedge clock);
		sleep_exec <= 1'b1;
		@(posedge clock);
		sleep_exec <= 1'b0;
		#1;
		chk("enter_idle", enter_idle, idle);
		chk("enter_sleep", enter_sleep, !idle);
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		// full run is a few thousand cycles; 20,000 leaves ample margin
		#400_000;
		mismatches++;
		final_report();
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] v;
		logic [2:0] f;
		int         n;
		int         ex;
		rst_n = 1'b0;
		bus_req = '0;
		sec_run = 1'b0;
		startup_expired = 1'b1;
		fast_osc_stable = 1'b0;
		two_speed = 1'b1;
		mode_cfg = OSW_MODE_INTA;
		sleep_exec = 1'b0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		foreach (ROWS[i]) begin
			wr(ROWS[i].a, ROWS[i].w);
			rd(ROWS[i].a, v);
			chk("register", v, ROWS[i].e);
		end
		// secondary still disabled: the select must be ignored
		wr(OSW_ADDR_OSC_CTRL, 8'h41);
		chk("busy refused", switch_busy, 1'b0);
		rd(OSW_ADDR_OSC_CTRL, v);
		chk("ctrl refused", v, 8'h48);
		sec_run <= 1'b1;
		wr(OSW_ADDR_SEC_CTRL, 8'h08);
		wr(OSW_ADDR_OSC_CTRL, 8'h41);
		chk("busy", switch_busy, 1'b1);
		wait_sw(n);
		chk("pause ok", n >= P_PRI + 2 * P_SEC && n <= 2 * P_PRI + 3 * P_SEC + 3, 1'b1);
		chk("active sec", active_source, OSW_SRC_SEC);
		rd(OSW_ADDR_SEC_CTRL, v);
		chk("sec ctrl", v, 8'h48);
		rd(OSW_ADDR_OSC_CTRL, v);
		chk("ctrl on sec", v, 8'h41);
		fast_osc_stable <= 1'b1;
		wr(OSW_ADDR_OSC_CTRL, 8'h72);
		wait_sw(n);
		chk("active int", active_source[1], 1'b1);
		rd(OSW_ADDR_OSC_CTRL, v);
		chk("ctrl on int", v, 8'h76);
		rd(OSW_ADDR_SEC_CTRL, v);
		chk("sec ctrl off", v, 8'h08);
		for (int i = 0; i < 9; i++) begin
			f = (i < 8) ? 3'(7 - i) : 3'h0;
			wr(OSW_ADDR_TUNE, (i == 8) ? 8'hc0 : 8'h40);
			wr(OSW_ADDR_OSC_CTRL, {1'b0, f, 4'h2});
			per(n);
			ex = (f == 3'h0) ? ((i == 8) ? 256 * P_FAST : P_LP) : (P_FAST << i);
			chk("period", 16'(n), 16'(ex));
			chk("multiplier", multiplier_active, f >= 3'h6);
		end
		wr(OSW_ADDR_OSC_CTRL, 8'hc2);
		slp(1'b1);
		wr(OSW_ADDR_OSC_CTRL, 8'h42);
		slp(1'b0);
		// second choice lands mid-pause: handover restarts from the internal block
		wr(OSW_ADDR_OSC_CTRL, 8'h41);
		wr(OSW_ADDR_OSC_CTRL, 8'h40);
		chk("busy restart", switch_busy, 1'b1);
		wait_sw(n);
		chk("active pri", active_source, OSW_SRC_PRI);
		rd(OSW_ADDR_OSC_CTRL, v);
		chk("ctrl on pri", v, 8'h48);
		// count ran high against the reference: step the trim down from centre
		wr(OSW_ADDR_TUNE, 8'h00);
		wr(OSW_ADDR_TUNE, 8'h1f);
		chk("tune", tune_value, 5'h1f);
		chk("wdt tick", 16'(wdt_bad), 16'h0000);
		chk("glitches", 16'(glitches), 16'h0000);
		startup_expired <= 1'b0;
		sec_run <= 1'b0;
		rst_n <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		chk("active reset", active_source, OSW_SEL_RST);
		rst_n <= 1'b1;
		rd(OSW_ADDR_OSC_CTRL, v);
		chk("ctrl reset", v, 8'h40);
		rd(OSW_ADDR_TUNE, v);
		chk("tune reset", v, 8'h00);
		rd(OSW_ADDR_SEC_CTRL, v);
		chk("sec reset", v, 8'h00);
		chk("primary mode", primary_mode, OSW_MODE_INTA);
		// straps changed: two-speed off, a mode outside the internal-block pair
		two_speed <= 1'b0;
		mode_cfg <= 4'h2;
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		rd(OSW_ADDR_OSC_CTRL, v);
		chk("ctrl strap off", v, 8'h48);
		wr(OSW_ADDR_TUNE, 8'h40);
		rd(OSW_ADDR_TUNE, v);
		chk("mult gated", v, 8'h00);
		chk("primary mode off", primary_mode, 4'h2);
		final_report();
	end
endmodule
`default_nettype wire
